// *** rtl/retimer_output_mux_override.v ***
// Output source selection and VCO divider override for one retimer channel.
// Assumes register accesses arrive already decoded from the serial
// management interface as address, data and one-cycle strobes on clk.
// One channel only: channel selection lives in the management logic.
// Reads and writes may come back to back; a same-cycle read sees the old value.
`timescale 1ns/1ps
`include "retimer_mux_defs.vh"

module retimer_output_mux_override
(
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Register access from the management interface
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata_ff,
	output reg        reg_rvalid_ff,
	// Channel status from the analog front end
	input  wire       signal_present,
	input  wire       cdr_locked,
	input  wire [2:0] auto_divider_code,
	// Output sources
	input  wire       retimed_bit,
	input  wire       raw_bit,
	input  wire       prbs_bit,
	input  wire       vco_inphase_clock,
	input  wire       vco_quadrature_clock,
	input  wire       osc_10mhz,
	// Channel output
	output wire       channel_out_ff,
	output wire       channel_muted_ff,
	// Analog controls
	output reg        channel_enable_ff,
	output reg        vco_free_run_ff,
	output reg        coarse_research_en_ff,
	output reg  [2:0] active_source_ff,
	output reg  [2:0] divider_code_ff,
	output reg  [4:0] divide_ratio_ff
);

	// ****************************************
	// Helpers
	// ****************************************
	// One-hot ratio from the code; unused codes fall back to divide by one
	function [4:0] code_to_ratio;
		input [2:0] code;
		begin
			case (code)
				`DIV_CODE_BY1:  code_to_ratio = `DIV_RATIO_1;
				`DIV_CODE_BY2:  code_to_ratio = `DIV_RATIO_2;
				`DIV_CODE_BY4:  code_to_ratio = `DIV_RATIO_4;
				`DIV_CODE_BY8:  code_to_ratio = `DIV_RATIO_8;
				`DIV_CODE_BY16: code_to_ratio = `DIV_RATIO_16;
				default: code_to_ratio = `DIV_RATIO_1;
			endcase
		end
	endfunction

	// Saturate rather than wrap, so a bad front end code never picks divide by one
	function [2:0] clamp_code;
		input [2:0] code;
		begin
			if (code > `DIV_CODE_MAX)
				clamp_code = `DIV_CODE_MAX;
			else
				clamp_code = code;
		end
	endfunction

	// ****************************************
	// Register file
	// ****************************************
	reg [7:0] override_control_ff;
	reg [7:0] signal_detect_force_ff;
	reg [7:0] vco_divider_select_ff;
	reg [7:0] output_source_select_ff;
	reg [7:0] raw_mode_control_ff;

	wire [2:0] wr_div_field;
	assign wr_div_field = reg_wdata[`DIV_FIELD_HI:`DIV_FIELD_LO];

	always @(posedge clk)
	begin
		if (rst)
		begin
			override_control_ff     <= `RST_OVERRIDE_CONTROL;
			signal_detect_force_ff  <= `RST_SIGNAL_DETECT_FORCE;
			vco_divider_select_ff   <= `RST_VCO_DIVIDER_SELECT;
			output_source_select_ff <= `RST_OUTPUT_SOURCE_SEL;
			raw_mode_control_ff     <= `RST_RAW_MODE_CONTROL;
		end
		else if (reg_write)
		begin
			case (reg_addr)
				`ADDR_OVERRIDE_CONTROL:    override_control_ff     <= reg_wdata;
				`ADDR_SIGNAL_DETECT_FORCE: signal_detect_force_ff  <= reg_wdata;
				`ADDR_VCO_DIVIDER_SELECT:
				begin
					// Out-of-range divider codes keep the previous field
					if (wr_div_field <= `DIV_CODE_MAX)
						vco_divider_select_ff <= reg_wdata;
					else
						vco_divider_select_ff <= (reg_wdata & ~`DIV_FIELD_MASK) |
							(vco_divider_select_ff & `DIV_FIELD_MASK);
				end
				`ADDR_OUTPUT_SOURCE_SEL:   output_source_select_ff <= reg_wdata;
				`ADDR_RAW_MODE_CONTROL:    raw_mode_control_ff     <= reg_wdata;
				// Unmapped and read-only addresses store nothing
				default:                   override_control_ff     <= override_control_ff;
			endcase
		end
	end

	// ****************************************
	// Signal detect and source resolution
	// ****************************************
	wire force_on;
	wire force_off;
	wire detect_effective;
	wire outmux_override;
	wire [2:0] source_field;
	wire prbs_enabled;
	wire quad_enabled;
	reg  [2:0] nxt_active_source;

	assign force_on  = signal_detect_force_ff[`SDF_FORCE_ON_BIT] &
		~signal_detect_force_ff[`SDF_FORCE_OFF_BIT];
	// Both force bits set counts as automatic, the same as both clear
	assign force_off = signal_detect_force_ff[`SDF_FORCE_OFF_BIT] &
		~signal_detect_force_ff[`SDF_FORCE_ON_BIT];
	// Both bits clear hands detection back to the front end
	assign detect_effective = force_on | (~force_off & signal_present);

	assign outmux_override = override_control_ff[`OVR_OUTMUX_BIT];
	assign source_field    = output_source_select_ff[`SRC_FIELD_HI:`SRC_FIELD_LO];
	assign prbs_enabled    = output_source_select_ff[`SRC_PRBS_EN_BIT];
	assign quad_enabled    = output_source_select_ff[`SRC_QCLK_EN_BIT] &
		override_control_ff[`OVR_QCLK_EN_BIT];

	always @*
	begin
		// Detection outranks every override: a powered-down channel has no driver
		if (!detect_effective)
			nxt_active_source = `SRC_MUTE;
		else if (outmux_override)
			nxt_active_source = source_field;
		else if (cdr_locked)
			nxt_active_source = `SRC_RETIMED;
		else
			nxt_active_source = source_field;
	end

	// ****************************************
	// Channel controls
	// ****************************************
	wire       divider_override;
	wire [2:0] nxt_divider_code;
	wire       nxt_free_run;
	wire       nxt_research_en;

	assign divider_override = override_control_ff[`OVR_DIVIDER_BIT];
	// The override path needs no clamp: out-of-range writes never reach the field
	assign nxt_divider_code = divider_override ?
		vco_divider_select_ff[`DIV_FIELD_HI:`DIV_FIELD_LO] :
		clamp_code(auto_divider_code);
	// Without a real input the loop has nothing to track and the VCO runs open
	assign nxt_free_run = ~signal_present | override_control_ff[`OVR_PUMP_OFF_BIT];
	// Raw mode suppresses the coarse re-search that would mute the driver
	assign nxt_research_en = ~raw_mode_control_ff[`RAW_MODE_BIT];

	// Power and loop controls follow detection and raw mode with one register stage
	// Free-run tracks the raw detect: a forced channel still has no input to follow
	always @(posedge clk)
	begin
		if (rst)
		begin
			channel_enable_ff     <= `RST_CHANNEL_ENABLE;
			vco_free_run_ff       <= `RST_VCO_FREE_RUN;
			coarse_research_en_ff <= `RST_RESEARCH_EN;
		end
		else
		begin
			channel_enable_ff     <= detect_effective;
			vco_free_run_ff       <= nxt_free_run;
			coarse_research_en_ff <= nxt_research_en;
		end
	end

	// ****************************************
	// Resolved source
	// ****************************************
	// Registered in step with the mux so status and pin never disagree
	always @(posedge clk)
	begin
		if (rst)
			active_source_ff <= `SRC_MUTE;
		else
			active_source_ff <= nxt_active_source;
	end

	// ****************************************
	// Divider
	// ****************************************
	// Code and ratio update together, so the ratio never lags its code
	always @(posedge clk)
	begin
		if (rst)
		begin
			divider_code_ff <= `RST_DIVIDER_CODE;
			divide_ratio_ff <= `DIV_RATIO_1;
		end
		else
		begin
			divider_code_ff <= nxt_divider_code;
			divide_ratio_ff <= code_to_ratio(nxt_divider_code);
		end
	end

	// ****************************************
	// Output multiplexer
	// ****************************************
	// The mux takes the unregistered code so pin and status move on the same edge
	output_source_mux u_mux
	(
		.clk                  (clk),
		.rst                  (rst),
		.source_code          (nxt_active_source),
		.prbs_enabled         (prbs_enabled),
		.quad_enabled         (quad_enabled),
		.retimed_bit          (retimed_bit),
		.raw_bit              (raw_bit),
		.prbs_bit             (prbs_bit),
		.vco_inphase_clock    (vco_inphase_clock),
		.vco_quadrature_clock (vco_quadrature_clock),
		.osc_10mhz            (osc_10mhz),
		.channel_out_ff       (channel_out_ff),
		.channel_muted_ff     (channel_muted_ff)
	);

	// ****************************************
	// Register read-back
	// ****************************************
	// Status snapshot is read-only and shows the registered controls
	wire [7:0] status_word;
	reg  [7:0] nxt_rdata;

	assign status_word = {channel_enable_ff, vco_free_run_ff, active_source_ff, divider_code_ff};

	always @*
	begin
		case (reg_addr)
			`ADDR_OVERRIDE_CONTROL:    nxt_rdata = override_control_ff;
			`ADDR_SIGNAL_DETECT_FORCE: nxt_rdata = signal_detect_force_ff;
			`ADDR_VCO_DIVIDER_SELECT:  nxt_rdata = vco_divider_select_ff;
			`ADDR_OUTPUT_SOURCE_SEL:   nxt_rdata = output_source_select_ff;
			`ADDR_RAW_MODE_CONTROL:    nxt_rdata = raw_mode_control_ff;
			`ADDR_CHANNEL_STATUS:      nxt_rdata = status_word;
			default:                   nxt_rdata = `READ_UNMAPPED;
		endcase
	end

	// Valid is a one-cycle pulse, exactly one clock after the strobe
	always @(posedge clk)
	begin
		if (rst)
			reg_rvalid_ff <= `RST_READ_VALID;
		else
			reg_rvalid_ff <= reg_read;
	end

	// Read data holds between reads so a slow host may pick it up late
	always @(posedge clk)
	begin
		if (rst)
			reg_rdata_ff <= `RST_READ_DATA;
		else if (reg_read)
			reg_rdata_ff <= nxt_rdata;
	end

endmodule // retimer_output_mux_override

// *** rtl/retimer_mux_defs.vh ***
// Constants for the retimer channel output source and divider override block.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef RETIMER_MUX_DEFS_VH
`define RETIMER_MUX_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define ADDR_OVERRIDE_CONTROL   8'h09
`define ADDR_SIGNAL_DETECT_FORCE 8'h14
`define ADDR_VCO_DIVIDER_SELECT 8'h18
`define ADDR_OUTPUT_SOURCE_SEL  8'h1E
`define ADDR_RAW_MODE_CONTROL   8'h3F
`define ADDR_CHANNEL_STATUS     8'h7E

// ****************************************
// Reset values
// ****************************************
`define RST_OVERRIDE_CONTROL    8'h00
`define RST_SIGNAL_DETECT_FORCE 8'h00
`define RST_VCO_DIVIDER_SELECT  8'h00
`define RST_OUTPUT_SOURCE_SEL   8'hE0
`define RST_RAW_MODE_CONTROL    8'h00
`define RST_CHANNEL_ENABLE      1'b0
`define RST_VCO_FREE_RUN        1'b1
`define RST_RESEARCH_EN         1'b1
`define RST_DIVIDER_CODE        3'h0
`define RST_READ_DATA           8'h00
`define RST_READ_VALID          1'b0
`define READ_UNMAPPED           8'h00

// ****************************************
// Field positions
// ****************************************
`define OVR_CAPDAC_BIT          7
`define OVR_LPFDAC_BIT          6
`define OVR_OUTMUX_BIT          5
`define OVR_QCLK_EN_BIT         4
`define OVR_PUMP_OFF_BIT        3
`define OVR_DIVIDER_BIT         2
`define SDF_FORCE_ON_BIT        7
`define SDF_FORCE_OFF_BIT       6
`define DIV_FIELD_HI            6
`define DIV_FIELD_LO            4
`define DIV_FIELD_MASK          8'h70
`define SRC_FIELD_HI            7
`define SRC_FIELD_LO            5
`define SRC_PRBS_EN_BIT         4
`define SRC_QCLK_EN_BIT         0
`define RAW_MODE_BIT            7

// ****************************************
// Output source codes
// ****************************************
`define SRC_MUTE                3'h7
`define SRC_INVALID             3'h6
`define SRC_OSC_10MHZ           3'h5
`define SRC_PRBS                3'h4
`define SRC_VCO_QUAD            3'h3
`define SRC_VCO_INPHASE         3'h2
`define SRC_RETIMED             3'h1
`define SRC_RAW                 3'h0

// ****************************************
// Divider codes
// ****************************************
`define DIV_CODE_MAX            3'h4
`define DIV_CODE_BY1            3'h0
`define DIV_CODE_BY2            3'h1
`define DIV_CODE_BY4            3'h2
`define DIV_CODE_BY8            3'h3
`define DIV_CODE_BY16           3'h4
`define DIV_RATIO_1             5'h01
`define DIV_RATIO_2             5'h02
`define DIV_RATIO_4             5'h04
`define DIV_RATIO_8             5'h08
`define DIV_RATIO_16            5'h10

`endif

// *** rtl/output_source_mux.v ***
// Registered output multiplexer for one retimer channel.
// Assumes the source code is already resolved; all inputs share clk.
`timescale 1ns/1ps
`include "retimer_mux_defs.vh"

module output_source_mux
(
	// Clock and reset
	input  wire       clk,
	input  wire       rst,
	// Selection
	input  wire [2:0] source_code,
	input  wire       prbs_enabled,
	input  wire       quad_enabled,
	// Sources
	input  wire       retimed_bit,
	input  wire       raw_bit,
	input  wire       prbs_bit,
	input  wire       vco_inphase_clock,
	input  wire       vco_quadrature_clock,
	input  wire       osc_10mhz,
	// Result
	output reg        channel_out_ff,
	output reg        channel_muted_ff
);

	reg nxt_channel_out;
	reg nxt_channel_muted;

	always @*
	begin
		nxt_channel_out   = 1'b0;
		nxt_channel_muted = 1'b0;
		case (source_code)
			`SRC_RAW:         nxt_channel_out = raw_bit;
			`SRC_RETIMED:     nxt_channel_out = retimed_bit;
			`SRC_VCO_INPHASE: nxt_channel_out = vco_inphase_clock;
			// Quadrature path stays quiet until both enables are set
			`SRC_VCO_QUAD:
			begin
				nxt_channel_out   = vco_quadrature_clock & quad_enabled;
				nxt_channel_muted = ~quad_enabled;
			end
			`SRC_PRBS:
			begin
				nxt_channel_out   = prbs_bit & prbs_enabled;
				nxt_channel_muted = ~prbs_enabled;
			end
			`SRC_OSC_10MHZ:   nxt_channel_out = osc_10mhz;
			// Invalid code behaves as mute so the pin never floats to garbage
			`SRC_INVALID:     nxt_channel_muted = 1'b1;
			default:          nxt_channel_muted = 1'b1;
		endcase
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			channel_out_ff   <= 1'b0;
			channel_muted_ff <= 1'b1;
		end
		else
		begin
			channel_out_ff   <= nxt_channel_out;
			channel_muted_ff <= nxt_channel_muted;
		end
	end

endmodule // output_source_mux

// *** bench/output_mux_chk_sva.sv ***
// Concurrent checks on the ports of the output source and divider block.
// Assumes it is bound onto the block; helper regs mirror the control registers.
`timescale 1ns/1ps
module output_mux_chk
(
	// Clock and reset
	input logic       clk,
	input logic       rst,
	// Register writes
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic       reg_write,
	// Channel status and sources
	input logic       signal_present,
	input logic       cdr_locked,
	input logic [2:0] auto_divider_code,
	input logic       retimed_bit,
	input logic       osc_10mhz,
	// Results
	input logic       channel_out_ff,
	input logic       channel_muted_ff,
	input logic       channel_enable_ff,
	input logic [2:0] active_source_ff,
	input logic [2:0] divider_code_ff,
	input logic [4:0] divide_ratio_ff
);
	// ****************************************
	// Register mirror
	// ****************************************
	logic       ovr_ff;
	logic       dovr_ff;
	logic [2:0] src_ff;
	logic [2:0] div_ff;
	logic [1:0] sdf_ff;
	always @(posedge clk)
	begin
		if (rst)
		begin
			ovr_ff  <= 1'b0;
			dovr_ff <= 1'b0;
			src_ff  <= 3'h7;
			div_ff  <= 3'h0;
			sdf_ff  <= 2'h0;
		end
		else if (reg_write)
		begin
			if (reg_addr == 8'h09)
			begin
				ovr_ff  <= reg_wdata[5];
				dovr_ff <= reg_wdata[2];
			end
			if (reg_addr == 8'h1E)
				src_ff <= reg_wdata[7:5];
			if (reg_addr == 8'h14)
				sdf_ff <= reg_wdata[7:6];
			// Out-of-range divider codes are dropped, as the block does
			if (reg_addr == 8'h18 && reg_wdata[6:4] <= 3'h4)
				div_ff <= reg_wdata[6:4];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ****************************************
	// Assertions
	// ****************************************
	chk_locked_retimed: assert property (!ovr_ff && sdf_ff == 2'h0 && signal_present && cdr_locked
		|=> active_source_ff == 3'h1) else $error("locked channel not retimed");
	chk_unlocked_field: assert property (!ovr_ff && sdf_ff == 2'h0 && signal_present && !cdr_locked
		|=> active_source_ff == $past(src_ff)) else $error("unlocked channel ignores field");
	chk_no_signal_mute: assert property (sdf_ff == 2'h0 && !signal_present
		|=> active_source_ff == 3'h7 && !channel_enable_ff) else $error("no signal but channel live");
	chk_override_follows: assert property (ovr_ff && sdf_ff == 2'h2
		|=> active_source_ff == $past(src_ff) && channel_enable_ff) else $error("override not followed");
	chk_invalid_mute: assert property (active_source_ff >= 3'h6
		|-> channel_muted_ff && !channel_out_ff) else $error("mute codes drive output");
	chk_retimed_path: assert property (active_source_ff == 3'h1
		|-> !channel_muted_ff && channel_out_ff == $past(retimed_bit)) else $error("retimed path wrong");
	chk_osc_path: assert property (active_source_ff == 3'h5
		|-> !channel_muted_ff && channel_out_ff == $past(osc_10mhz)) else $error("oscillator path wrong");
	chk_div_override: assert property (dovr_ff
		|=> divider_code_ff == $past(div_ff)) else $error("divider override ignored");
	chk_div_auto: assert property (!dovr_ff && auto_divider_code <= 3'h4
		|=> divider_code_ff == $past(auto_divider_code)) else $error("automatic divider wrong");
	chk_div_ratio: assert property (divide_ratio_ff == (5'h01 << divider_code_ff))
		else $error("ratio does not match code");
	cover property (active_source_ff == 3'h5);
	cover property (dovr_ff && divider_code_ff == 3'h4);
	cover property (channel_enable_ff && !signal_present);
endmodule // output_mux_chk

bind retimer_output_mux_override output_mux_chk u_chk (.*);

// *** bench/host_model.sv ***
// Management host that issues decoded register strobes to the block.
// Assumes one clock shared with the block and no request during reset.
`timescale 1ns/1ps
module host_model
(
	// Clock
	input  logic       clk,
	// Register strobes
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic       reg_write,
	output logic       reg_read,
	// Read return
	input  logic [7:0] reg_rdata_ff,
	input  logic       reg_rvalid_ff
);
	initial
	begin
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read  = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
		// Released data must not look like it still holds the value
		reg_wdata <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		d = reg_rvalid_ff ? reg_rdata_ff : 8'hXX;
	endtask
endmodule // host_model

// *** bench/test_retimer_output_mux_override.sv ***
// Self-checking bench for the output source and divider override block.
// Assumes the checker is bound in and the host model owns the register strobes.
`timescale 1ns/1ps
module test_retimer_output_mux_override;
	logic        clk, rst, signal_present, cdr_locked;
	logic [2:0]  auto_divider_code;
	logic        retimed_bit, raw_bit, prbs_bit, vco_inphase_clock, vco_quadrature_clock, osc_10mhz;
	wire  [7:0]  reg_addr, reg_wdata, reg_rdata_ff;
	wire         reg_write, reg_read, reg_rvalid_ff, channel_out_ff, channel_muted_ff;
	wire         channel_enable_ff, vco_free_run_ff, coarse_research_en_ff;
	wire  [2:0]  active_source_ff, divider_code_ff;
	wire  [4:0]  divide_ratio_ff;
	logic [31:0] seed;
	int          miscompares, checked;
	logic [7:0]  ra [6] = '{8'h09, 8'h14, 8'h18, 8'h1E, 8'h3F, 8'h55};
	logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h00};

	retimer_output_mux_override dut (.*);
	host_model host (.*);

	function logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function logic [7:0] div_exp(input logic [2:0] c);
		logic [2:0] k;
		k = (c > 3'h4) ? 3'h4 : c;
		return {5'h01 << k, k};
	endfunction
	// ****************************************
	// Checking and closing
	// ****************************************
	task cmp_out(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task cmp_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd(a, v);
		cmp_out(v, exp);
	endtask
	task look(input logic e, input logic m, input logic [2:0] c);
		cmp_out({channel_enable_ff, channel_muted_ff, 3'h0, active_source_ff}, {e, m, 3'h0, c});
	endtask
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task stat(input logic s, input logic l);
		@(posedge clk);
		signal_present <= s;
		cdr_locked     <= l;
		settle;
	endtask
	task close_out;
		if (miscompares == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ****************************************
	// Clock, random sources, watchdog
	// ****************************************
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk)
	begin
		seed <= xs(seed);
		{retimed_bit, raw_bit, prbs_bit, vco_inphase_clock, vco_quadrature_clock, osc_10mhz} <= seed[5:0];
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		close_out;
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		rst = 1'b1;
		seed = 32'hA9CB;
		{signal_present, cdr_locked, auto_divider_code} = 5'h00;
		{retimed_bit, raw_bit, prbs_bit, vco_inphase_clock, vco_quadrature_clock, osc_10mhz} = 6'h00;
		miscompares = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
			cmp_reg(ra[i], rv[i]);
		cmp_out({7'h00, coarse_research_en_ff}, 8'h01);
		stat(1'b0, 1'b0);
		look(1'b0, 1'b1, 3'h7);
		stat(1'b1, 1'b0);
		look(1'b1, 1'b1, 3'h7);
		stat(1'b1, 1'b1);
		look(1'b1, 1'b0, 3'h1);
		host.wr(8'h1E, 8'h00);
		stat(1'b1, 1'b0);
		look(1'b1, 1'b0, 3'h0);
		host.wr(8'h3F, 8'h80);
		host.wr(8'h09, 8'h30);
		settle;
		cmp_out({7'h00, coarse_research_en_ff}, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			host.wr(8'h1E, {c[2:0], 5'h11});
			stat(1'b1, c[0]);
			look(1'b1, c > 5, c[2:0]);
		end
		stat(1'b0, 1'b0);
		host.wr(8'h14, 8'h80);
		host.wr(8'h1E, 8'hA0);
		settle;
		look(1'b1, 1'b0, 3'h5);
		host.wr(8'h1E, 8'h20);
		settle;
		look(1'b1, 1'b0, 3'h1);
		cmp_out({7'h00, vco_free_run_ff}, 8'h01);
		host.wr(8'h14, 8'h00);
		settle;
		look(1'b0, 1'b1, 3'h7);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk);
			auto_divider_code <= seed[10:8];
			settle;
			cmp_out({divide_ratio_ff, divider_code_ff}, div_exp(auto_divider_code));
		end
		@(posedge clk);
		auto_divider_code <= 3'h2;
		host.wr(8'h09, 8'h2C);
		for (int k = 0; k < 5; k++)
		begin
			host.wr(8'h18, {1'b0, k[2:0], 4'h0});
			settle;
			cmp_out({divide_ratio_ff, divider_code_ff}, div_exp(k[2:0]));
		end
		host.wr(8'h18, 8'h70);
		settle;
		cmp_out({divide_ratio_ff, divider_code_ff}, div_exp(3'h4));
		cmp_reg(8'h18, 8'h40);
		host.wr(8'h09, 8'h00);
		stat(1'b1, 1'b1);
		look(1'b1, 1'b0, 3'h1);
		cmp_out({divide_ratio_ff, divider_code_ff}, div_exp(3'h2));
		cmp_reg(8'h7E, 8'h8A);
		close_out;
	end
endmodule // test_retimer_output_mux_override
